/* File: hw/cis_sequencer.sv */
/*
 * Interrupt entry and return sequencer of the core.
 * Assumes the core pulses i_instr_done at each instruction boundary,
 * gives op strobes with that pulse, and stalls while o_core_hold is high.
 * Stack memory returns read data one cycle after o_stack_re.
 */
`timescale 1ns/10ps

module cis_sequencer #(
    parameter int N_SRC = cis_pkg::N_SRC_DEF
) (
    // Core clock, undivided, and reset
    input wire logic i_ref_clk,
    input wire logic i_reset_n,
    // Interrupt sources
    input wire logic [N_SRC-1:0] i_flag_event,
    input wire logic [N_SRC-1:0] i_level_req,
    input wire logic [N_SRC-1:0] i_src_is_level,
    input wire logic [N_SRC-1:0] i_src_enable,
    input wire logic [N_SRC-1:0] i_flag_clear_wr,
    output logic [N_SRC-1:0] o_flag_pending,
    // Instruction sequencer
    input wire logic i_instr_done,
    input wire logic i_op_sei,
    input wire logic i_global_disable_op,
    input wire logic i_return_from_irq_op,
    input wire logic i_flags_wr,
    input wire logic i_flags_gie,
    input wire logic [cis_pkg::PC_W-1:0] i_program_counter,
    output logic o_global_enable,
    output logic o_core_hold,
    output logic o_irq_ack,
    output logic o_vector_valid,
    output logic [cis_pkg::PC_W-1:0] o_vector_addr,
    output logic o_pc_restore_valid,
    output logic [cis_pkg::PC_W-1:0] o_pc_restore,
    // Sleep
    input wire logic i_sleeping,
    input wire logic i_wake_ready,
    output logic o_wake_req,
    // Stack pointer and stack memory
    input wire logic i_sp_load,
    input wire logic [cis_pkg::SP_W-1:0] i_sp_wdata,
    output logic [cis_pkg::SP_W-1:0] o_sp,
    output logic o_stack_we,
    output logic o_stack_re,
    output logic [cis_pkg::SP_W-1:0] o_stack_addr,
    output logic [cis_pkg::BYTE_W-1:0] o_stack_wdata,
    input wire logic [cis_pkg::BYTE_W-1:0] i_stack_rdata
);
    localparam int IW = (N_SRC > 1) ? $clog2(N_SRC) : 1;
    localparam int HI_W = cis_pkg::PC_W - cis_pkg::BYTE_W;

    cis_irq_if #(.N(N_SRC), .IW(IW)) irq ();

    // Flags and request merge
    cis_flag_bank #(.N(N_SRC)) u_bank (
        .i_ref_clk(i_ref_clk),
        .i_reset_n(i_reset_n),
        .i_event(i_flag_event),
        .i_level(i_level_req),
        .i_is_level(i_src_is_level),
        .i_clr_wr(i_flag_clear_wr),
        .o_flags(o_flag_pending),
        .irq(irq)
    );

    // Priority pick
    cis_arbiter #(.N(N_SRC), .IW(IW)) u_arb (
        .i_ref_clk(i_ref_clk),
        .i_reset_n(i_reset_n),
        .irq(irq)
    );

    // Sequencer state
    cis_pkg::cis_state_t state_reg, state_next;
    cis_pkg::cis_cnt_t cnt_reg, cnt_next;
    logic [IW-1:0] sel_reg, sel_next;  // Latched winner
    logic [cis_pkg::PC_W-1:0] pc_save_reg, pc_save_next;  // Address to push
    logic [cis_pkg::BYTE_W-1:0] pop_hi_reg, pop_hi_next;  // Popped high byte
    logic [cis_pkg::SP_W-1:0] sp_reg, sp_next;
    logic gie_reg, gie_next;  // Global enable
    logic hold_off_reg, hold_off_next;  // One instruction must run first
    // Registered outputs
    logic hold_reg, hold_next;
    logic ack_reg, ack_next;
    logic vec_valid_reg, vec_valid_next;
    logic [cis_pkg::PC_W-1:0] vec_addr_reg, vec_addr_next;
    logic rest_valid_reg, rest_valid_next;
    logic [cis_pkg::PC_W-1:0] rest_reg, rest_next;
    logic wake_reg, wake_next;
    logic we_reg, we_next;
    logic re_reg, re_next;
    logic [cis_pkg::SP_W-1:0] addr_reg, addr_next;
    logic [cis_pkg::BYTE_W-1:0] wdata_reg, wdata_next;
    logic take_ok;  // Accept a request this cycle

    assign irq.en = i_src_enable;

    // Acceptance: boundary or sleep, global enable, no blockers
    always_comb
    begin
        take_ok = (state_reg == cis_pkg::ST_RUN) && gie_reg && irq.sel_valid
            && !i_global_disable_op && !i_op_sei && !hold_off_reg
            && !i_return_from_irq_op && (i_instr_done || i_sleeping);
    end

    // Next state and outputs
    always_comb
    begin
        state_next = state_reg;
        cnt_next = cnt_reg + cis_pkg::CNT_ONE;
        sel_next = sel_reg;
        pc_save_next = pc_save_reg;
        pop_hi_next = pop_hi_reg;
        sp_next = sp_reg;
        gie_next = gie_reg;
        hold_off_next = hold_off_reg;
        ack_next = 1'b0;
        vec_valid_next = 1'b0;
        vec_addr_next = vec_addr_reg;
        rest_valid_next = 1'b0;
        rest_next = rest_reg;
        we_next = 1'b0;
        re_next = 1'b0;
        addr_next = addr_reg;
        wdata_next = wdata_reg;
        irq.hw_clr = '0;
        // Boundary reached, the deferred instruction has run
        if (i_instr_done)
            hold_off_next = 1'b0;
        // Software writes only the enable bit; other flags stay with the core
        if (i_flags_wr)
            gie_next = i_flags_gie;
        if (i_op_sei)
        begin
            gie_next = 1'b1;
            hold_off_next = 1'b1;
        end
        if (i_global_disable_op)
            gie_next = 1'b0;
        case (state_reg)
            cis_pkg::ST_RUN:
            begin
                // Software stack pointer load
                if (i_sp_load)
                    sp_next = i_sp_wdata;
                if (i_return_from_irq_op && i_instr_done)
                begin
                    // Pop high byte first, at sp+1
                    state_next = cis_pkg::ST_RETURN;
                    cnt_next = cis_pkg::CNT_ZERO;
                    re_next = 1'b1;
                    addr_next = sp_reg + cis_pkg::SP_ONE;
                end
                else if (take_ok)
                begin
                    sel_next = irq.sel_idx;
                    pc_save_next = i_program_counter;
                    gie_next = 1'b0;
                    ack_next = 1'b1;
                    irq.hw_clr[irq.sel_idx] = ~i_src_is_level[irq.sel_idx];
                    cnt_next = cis_pkg::CNT_ZERO;
                    state_next = i_sleeping ? cis_pkg::ST_WAKE : cis_pkg::ST_ENTRY;
                end
            end
            cis_pkg::ST_WAKE:
            begin
                // Extra cycles count only after start-up completes
                if (!i_wake_ready)
                    cnt_next = cis_pkg::CNT_ZERO;
                else if (cnt_reg == cis_pkg::cis_cnt_t'(cis_pkg::WAKE_CYCLES - 1))
                begin
                    state_next = cis_pkg::ST_ENTRY;
                    cnt_next = cis_pkg::CNT_ZERO;
                end
            end
            cis_pkg::ST_ENTRY:
            begin
                // Low byte at sp, high byte at sp-1, then sp-2
                if (cnt_reg == cis_pkg::CNT_ZERO)
                begin
                    we_next = 1'b1;
                    addr_next = sp_reg;
                    wdata_next = pc_save_reg[cis_pkg::BYTE_W-1:0];
                end
                else if (cnt_reg == cis_pkg::CNT_ONE)
                begin
                    we_next = 1'b1;
                    addr_next = sp_reg - cis_pkg::SP_ONE;
                    wdata_next = {{(2 * cis_pkg::BYTE_W - cis_pkg::PC_W){1'b0}},
                        pc_save_reg[cis_pkg::PC_W-1:cis_pkg::BYTE_W]};
                end
                else if (cnt_reg == cis_pkg::CNT_TWO)
                    sp_next = sp_reg - cis_pkg::SP_TWO;
                else
                begin
                    vec_valid_next = 1'b1;
                    vec_addr_next = cis_pkg::vector_addr(8'(sel_reg));
                    state_next = cis_pkg::ST_RUN;
                end
            end
            cis_pkg::ST_RETURN:
            begin
                if (cnt_reg == cis_pkg::CNT_ZERO)
                begin
                    // Low byte request at sp+2
                    re_next = 1'b1;
                    addr_next = sp_reg + cis_pkg::SP_TWO;
                end
                else if (cnt_reg == cis_pkg::CNT_ONE)
                    pop_hi_next = i_stack_rdata;
                else if (cnt_reg == cis_pkg::CNT_TWO)
                    rest_next = {pop_hi_reg[HI_W-1:0], i_stack_rdata};
                else
                begin
                    rest_valid_next = 1'b1;
                    sp_next = sp_reg + cis_pkg::SP_TWO;
                    gie_next = 1'b1;
                    hold_off_next = 1'b1;
                    state_next = cis_pkg::ST_RUN;
                end
            end
            default:
                state_next = cis_pkg::ST_RUN;
        endcase
        hold_next = (state_next != cis_pkg::ST_RUN);
        wake_next = (state_next == cis_pkg::ST_WAKE);
    end

    // State registers on the core clock
    always_ff @(posedge i_ref_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            state_reg <= cis_pkg::ST_RUN;
            cnt_reg <= cis_pkg::CNT_ZERO;
            sel_reg <= '0;
            pc_save_reg <= '0;
            pop_hi_reg <= '0;
            sp_reg <= '0;
            gie_reg <= 1'b0;
            hold_off_reg <= 1'b0;
            hold_reg <= 1'b0;
            ack_reg <= 1'b0;
            vec_valid_reg <= 1'b0;
            vec_addr_reg <= cis_pkg::VEC_RESET;
            rest_valid_reg <= 1'b0;
            rest_reg <= '0;
            wake_reg <= 1'b0;
            we_reg <= 1'b0;
            re_reg <= 1'b0;
            addr_reg <= '0;
            wdata_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            sel_reg <= sel_next;
            pc_save_reg <= pc_save_next;
            pop_hi_reg <= pop_hi_next;
            sp_reg <= sp_next;
            gie_reg <= gie_next;
            hold_off_reg <= hold_off_next;
            hold_reg <= hold_next;
            ack_reg <= ack_next;
            vec_valid_reg <= vec_valid_next;
            vec_addr_reg <= vec_addr_next;
            rest_valid_reg <= rest_valid_next;
            rest_reg <= rest_next;
            wake_reg <= wake_next;
            we_reg <= we_next;
            re_reg <= re_next;
            addr_reg <= addr_next;
            wdata_reg <= wdata_next;
        end
    end

    // Outputs straight from registers
    assign o_global_enable = gie_reg;
    assign o_core_hold = hold_reg;
    assign o_irq_ack = ack_reg;
    assign o_vector_valid = vec_valid_reg;
    assign o_vector_addr = vec_addr_reg;
    assign o_pc_restore_valid = rest_valid_reg;
    assign o_pc_restore = rest_reg;
    assign o_wake_req = wake_reg;
    assign o_sp = sp_reg;
    assign o_stack_we = we_reg;
    assign o_stack_re = re_reg;
    assign o_stack_addr = addr_reg;
    assign o_stack_wdata = wdata_reg;

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_reset_n);

    a_disable_blocks_take: assert property (i_global_disable_op |=> !o_irq_ack)
        else $error("request taken with global disable");
    a_take_needs_enable: assert property (take_ok |-> gie_reg && i_src_enable[irq.sel_idx])
        else $error("request taken while disabled");
    a_take_clears_gie: assert property (take_ok |=> !o_global_enable && o_irq_ack)
        else $error("global enable not cleared on take");
    a_entry_four_cycles: assert property ((take_ok && !i_sleeping) |=>
        o_core_hold [*4] ##1 (o_vector_valid && !o_core_hold))
        else $error("entry length wrong");
    a_push_lowers_sp: assert property ((take_ok && !i_sleeping && !i_sp_load) |->
        ##4 (o_sp == $past(o_sp, 4) - cis_pkg::SP_TWO))
        else $error("stack pointer not lowered by two");
    a_return_four_cycles: assert property ((state_reg == cis_pkg::ST_RUN && i_return_from_irq_op
        && i_instr_done) |=> o_core_hold [*4] ##1 (o_pc_restore_valid && o_global_enable))
        else $error("return length or enable wrong");
    a_one_instr_first: assert property ((hold_off_reg && i_instr_done) |=> !o_irq_ack)
        else $error("request taken before one instruction ran");
    a_choice_latched: assert property ((state_reg == cis_pkg::ST_ENTRY && cnt_reg != cis_pkg::CNT_ZERO)
        |-> $stable(sel_reg))
        else $error("selection changed during entry");
    a_vector_matches: assert property (o_vector_valid |->
        o_vector_addr == cis_pkg::vector_addr(8'(sel_reg)))
        else $error("vector address wrong");
    a_sei_defers: assert property (i_op_sei |-> !take_ok ##1 (!i_instr_done || !take_ok))
        else $error("request taken right after global enable");

    c_entry: cover property (take_ok && !i_sleeping ##5 o_vector_valid);
    c_return: cover property (o_pc_restore_valid);
    c_wake: cover property (state_reg == cis_pkg::ST_WAKE ##[1:40] o_vector_valid);
    c_nested: cover property (o_vector_valid ##[1:60] take_ok);
endmodule : cis_sequencer

/* File: hw/cis_pkg.sv */
/*
 * Shared constants, types and helpers for the interrupt sequencer.
 * Assumes a byte-wide stack memory and a word-addressed program memory.
 */
package cis_pkg;

    // Program counter and stack widths, default source count
    localparam int PC_W = 10;
    localparam int SP_W = 8;
    localparam int BYTE_W = 8;
    localparam int N_SRC_DEF = 8;

    // Sequence lengths in core clock cycles
    localparam int ENTRY_CYCLES = 4;
    localparam int RETURN_CYCLES = 4;
    localparam int WAKE_CYCLES = 4;

    // Vector table: reset at the bottom, sources above it
    localparam logic [PC_W-1:0] VEC_RESET = 10'h000;
    localparam logic [PC_W-1:0] VEC_STRIDE = 10'h001;

    // Stack pointer steps
    localparam logic [SP_W-1:0] SP_ONE = 8'h01;
    localparam logic [SP_W-1:0] SP_TWO = 8'h02;

    // Sequence step counter
    typedef logic [1:0] cis_cnt_t;
    localparam cis_cnt_t CNT_ZERO = 2'h0;
    localparam cis_cnt_t CNT_ONE = 2'h1;
    localparam cis_cnt_t CNT_TWO = 2'h2;

    // Sequencer states
    typedef enum logic [1:0] {ST_RUN, ST_WAKE, ST_ENTRY, ST_RETURN} cis_state_t;

    // Vector address of source index idx
    function automatic logic [PC_W-1:0] vector_addr(input logic [7:0] idx);
        logic [PC_W-1:0] slot;
        slot = PC_W'(idx) + 10'h001;
        vector_addr = VEC_RESET + PC_W'(slot * VEC_STRIDE);
    endfunction : vector_addr

endpackage : cis_pkg

/* File: hw/cis_irq_if.sv */
/*
 * Request and selection signals shared by flag bank, arbiter and sequencer.
 * Assumes all three parties sit in one clock domain.
 */
`timescale 1ns/10ps
interface cis_irq_if #(parameter int N = 8, parameter int IW = 3);
    logic [N-1:0] pend;      // Requests, flag or level
    logic [N-1:0] en;        // Per-source enables
    logic [N-1:0] hw_clr;    // Hardware flag clear on acceptance
    logic sel_valid;         // Some enabled request pending
    logic [IW-1:0] sel_idx;  // Winning source index

    modport bank (output pend, input hw_clr);
    modport arb (input pend, input en, output sel_valid, output sel_idx);
    modport seq (input pend, input sel_valid, input sel_idx, output en, output hw_clr);
endinterface : cis_irq_if

/* File: hw/cis_flag_bank.sv */
/*
 * Pending flags of flag-type sources, merged with level-type requests.
 * Assumes event, clear and type inputs are synchronous to the clock.
 */
`timescale 1ns/10ps
module cis_flag_bank #(
    parameter int N = 8
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_reset_n,
    // Source side
    input wire logic [N-1:0] i_event,
    input wire logic [N-1:0] i_level,
    input wire logic [N-1:0] i_is_level,
    input wire logic [N-1:0] i_clr_wr,
    // Flag state
    output logic [N-1:0] o_flags,
    // Towards arbiter and sequencer
    cis_irq_if.bank irq
);
    logic [N-1:0] flags_reg;   // Stored flags
    logic [N-1:0] flags_next;  // Next flags

    // Clears first, then events so a set wins
    always_comb
    begin
        flags_next = flags_reg & ~i_clr_wr & ~irq.hw_clr;
        flags_next = flags_next | (i_event & ~i_is_level);
    end

    // Flag registers
    always_ff @(posedge i_ref_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            flags_reg <= '0;
        else
            flags_reg <= flags_next;
    end

    // Level sources ask only while their condition holds
    assign irq.pend = (flags_reg & ~i_is_level) | (i_level & i_is_level);
    assign o_flags = flags_reg;

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_reset_n);

    a_event_sets_flag: assert property ((i_event & ~i_is_level) != '0 |=>
        (flags_reg & $past(i_event & ~i_is_level)) == $past(i_event & ~i_is_level))
        else $error("flag event lost");
    a_write_one_clears: assert property ((i_clr_wr & ~i_event) != '0 |=>
        (flags_reg & $past(i_clr_wr & ~i_event)) == '0)
        else $error("write one did not clear flag");
    a_hw_clear_flag: assert property ((irq.hw_clr & ~i_event) != '0 |=>
        (flags_reg & $past(irq.hw_clr & ~i_event)) == '0)
        else $error("accepted flag not cleared");
endmodule : cis_flag_bank

/* File: hw/cis_arbiter.sv */
/*
 * Fixed priority pick: the lowest enabled pending index wins.
 * Assumes index zero is the external request right below reset.
 */
`timescale 1ns/10ps
module cis_arbiter #(
    parameter int N = 8,
    parameter int IW = 3
) (
    // Clock and reset, used by checks only
    input wire logic i_ref_clk,
    input wire logic i_reset_n,
    // Requests in, choice out
    cis_irq_if.arb irq
);
    // Lowest set bit of a request vector
    function automatic logic [IW-1:0] lowest(input logic [N-1:0] req);
        lowest = '0;
        for (int k = N - 1; k >= 0; k--)
        begin
            if (req[k])
                lowest = IW'(k);
        end
    endfunction : lowest

    logic [N-1:0] live;  // Pending and enabled

    // Priority by index, lower vector first
    always_comb
    begin
        live = irq.pend & irq.en;
        irq.sel_valid = |live;
        irq.sel_idx = lowest(live);
    end

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_reset_n);

    a_lowest_first: assert property (irq.sel_valid |->
        (live & ((N'(1) << irq.sel_idx) - N'(1))) == '0 && live[irq.sel_idx])
        else $error("winner is not the lowest live source");
endmodule : cis_arbiter

/* File: verif/cis_stack_model.sv */
/*
 * Byte-wide stack memory on the far side of the sequencer.
 * Assumes read data is wanted one cycle after the read strobe.
 */
`timescale 1ns/10ps
module cis_stack_model (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_reset_n,
    // Stack port of the sequencer
    input wire logic i_we,
    input wire logic i_re,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_rdata
);
    logic [7:0] mem [256]; // Stack bytes

    // Store pushes, answer pops; an idle bus flips so stale data never passes
    always_ff @(posedge i_ref_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            o_rdata <= 8'h00;
        else if (i_re)
            o_rdata <= mem[i_addr];
        else
            o_rdata <= ~o_rdata;
        if (i_we)
            mem[i_addr] <= i_wdata;
    end
endmodule : cis_stack_model

/* File: verif/cis_sequencer_tb.sv */
/*
 * Self-checking bench for the interrupt sequencer.
 * Assumes the stack model answers pops; sleep is entered once, with a slow start-up.
 */
`timescale 1ns/10ps
module cis_sequencer_tb;
    logic i_ref_clk = 1'b0;
    logic i_reset_n = 1'b0;
    logic [7:0] ev = 8'h00; // Flag events
    logic [7:0] lvl = 8'h00; // Level conditions
    logic [7:0] is_lvl = 8'h00; // Source types
    logic [7:0] en = 8'h00; // Source enables
    logic [7:0] clr = 8'h00; // Write-one-clear
    logic done = 1'b0, sei = 1'b0, gdis = 1'b0, rtn = 1'b0, fwr = 1'b0, fgie = 1'b0, spld = 1'b0;
    logic slp = 1'b0, wrdy = 1'b0; // Asleep, start-up done
    logic [9:0] pc = 10'h2a5; // Address to push
    logic [7:0] spw = 8'h80; // Stack pointer value
    logic [7:0] flg, sp, sa, sw, sr;
    logic gie, hold, ack, vv, rv, wk, swe, sre;
    logic [9:0] va, rpc;
    int errors = 0;
    int checks = 0;
    int cyc = 0;

    // Core clock, 4 ns period
    always #2 i_ref_clk = ~i_ref_clk;

    cis_sequencer #(.N_SRC(8)) u_cis_sequencer (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n),
        .i_flag_event(ev), .i_level_req(lvl), .i_src_is_level(is_lvl), .i_src_enable(en),
        .i_flag_clear_wr(clr), .o_flag_pending(flg), .i_instr_done(done), .i_op_sei(sei),
        .i_global_disable_op(gdis), .i_return_from_irq_op(rtn), .i_flags_wr(fwr),
        .i_flags_gie(fgie), .i_program_counter(pc), .o_global_enable(gie), .o_core_hold(hold),
        .o_irq_ack(ack), .o_vector_valid(vv), .o_vector_addr(va), .o_pc_restore_valid(rv),
        .o_pc_restore(rpc), .i_sleeping(slp), .i_wake_ready(wrdy), .o_wake_req(wk),
        .i_sp_load(spld), .i_sp_wdata(spw), .o_sp(sp), .o_stack_we(swe), .o_stack_re(sre),
        .o_stack_addr(sa), .o_stack_wdata(sw), .i_stack_rdata(sr));

    cis_stack_model u_cis_stack_model (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_we(swe),
        .i_re(sre), .i_addr(sa), .i_wdata(sw), .o_rdata(sr));

    // Verdict and end of run
    task automatic report_and_stop();
        if (errors == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : report_and_stop

    // Hang guard
    always @(posedge i_ref_clk)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            errors++;
            report_and_stop();
        end
    end

    // One comparison
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // One instruction boundary with optional ops
    task automatic instr(input logic s, input logic g, input logic r);
        @(posedge i_ref_clk);
        done <= 1'b1;
        sei <= s;
        gdis <= g;
        rtn <= r;
        @(posedge i_ref_clk);
        {done, sei, gdis, rtn} <= 4'h0;
        #1;
    endtask : instr

    // Event and clear pulses, or a software enable write
    task automatic src(input logic [7:0] e, input logic [7:0] c, input logic w);
        @(posedge i_ref_clk);
        ev <= e;
        clr <= c;
        fwr <= w;
        fgie <= w;
        @(posedge i_ref_clk);
        {ev, clr, fwr, fgie} <= 18'h0;
        #1;
    endtask : src

    // Entry from the take edge to the vector jump
    task automatic take_check(input logic [9:0] vec);
        int n;
        n = 0;
        chk("ack", 16'h1, {15'h0, ack});
        chk("gie_entry", 16'h0, {15'h0, gie});
        while (vv !== 1'b1 && n < 8)
        begin
            @(posedge i_ref_clk);
            #1;
            n++;
        end
        chk("entry_len", 16'h4, 16'(n));
        chk("vector", {6'h0, vec}, {6'h0, va});
        chk("sp_push", 16'h7e, {8'h0, sp});
    endtask : take_check

    // Return and restore of the pushed counter
    task automatic ret_check();
        int n;
        n = 0;
        instr(1'b0, 1'b0, 1'b1);
        while (rv !== 1'b1 && n < 8)
        begin
            @(posedge i_ref_clk);
            #1;
            n++;
        end
        chk("ret_len", 16'h4, 16'(n));
        chk("pc_back", {6'h0, pc}, {6'h0, rpc});
        chk("sp_pop", 16'h80, {8'h0, sp});
        chk("gie_ret", 16'h1, {15'h0, gie});
    endtask : ret_check

    // No acceptance for several cycles
    task automatic no_take();
        repeat (6)
        begin
            chk("no_ack", 16'h0, {15'h0, ack});
            @(posedge i_ref_clk);
            #1;
        end
    endtask : no_take

    // Held flags, priority, clearing and return spacing
    task automatic t_flags();
        src(8'h24, 8'h00, 1'b0);
        chk("flag_held", 16'h24, {8'h0, flg});
        en <= 8'hff;
        src(8'h00, 8'h00, 1'b1);
        instr(1'b0, 1'b0, 1'b0);
        take_check(10'h003);
        chk("hw_clear", 16'h20, {8'h0, flg});
        ret_check();
        instr(1'b0, 1'b0, 1'b0);
        no_take();
        instr(1'b0, 1'b0, 1'b0);
        take_check(10'h006);
        src(8'h80, 8'h00, 1'b0);
        src(8'h00, 8'h7f, 1'b0);
        chk("clr_zero", 16'h80, {8'h0, flg});
        src(8'h00, 8'h80, 1'b0);
        chk("clr_one", 16'h00, {8'h0, flg});
        ret_check();
    endtask : t_flags

    // Same-cycle disable, then enable instruction spacing
    task automatic t_ops();
        instr(1'b0, 1'b0, 1'b0);
        src(8'h01, 8'h00, 1'b0);
        instr(1'b0, 1'b1, 1'b0);
        no_take();
        chk("gie_off", 16'h0, {15'h0, gie});
        instr(1'b1, 1'b0, 1'b0);
        instr(1'b0, 1'b0, 1'b0);
        no_take();
        instr(1'b0, 1'b0, 1'b0);
        take_check(10'h001);
        ret_check();
    endtask : t_ops

    // Level source gated by its enable
    task automatic t_level();
        en <= 8'hef;
        is_lvl <= 8'h10;
        lvl <= 8'h10;
        instr(1'b0, 1'b0, 1'b0);
        instr(1'b0, 1'b0, 1'b0);
        no_take();
        en <= 8'hff;
        instr(1'b0, 1'b0, 1'b0);
        take_check(10'h005);
        lvl <= 8'h00;
        ret_check();
        en <= 8'hef;
        lvl <= 8'h10;
        instr(1'b0, 1'b0, 1'b0);
        lvl <= 8'h00;
        instr(1'b0, 1'b0, 1'b0);
        en <= 8'hff;
        instr(1'b0, 1'b0, 1'b0);
        no_take();
    endtask : t_level

    // Wake from sleep: wait for start-up, four extra cycles, then entry
    task automatic t_sleep();
        int n;
        n = 0;
        src(8'h40, 8'h00, 1'b0);
        @(posedge i_ref_clk);
        slp <= 1'b1;
        @(posedge i_ref_clk);
        slp <= 1'b0;
        #1;
        chk("ack_sleep", 16'h1, {15'h0, ack});
        repeat (3)
        begin
            chk("wake_wait", 16'h1, {15'h0, wk});
            chk("hold_wake", 16'h1, {15'h0, hold});
            @(posedge i_ref_clk);
            #1;
        end
        @(posedge i_ref_clk);
        wrdy <= 1'b1;
        #1;
        while (vv !== 1'b1 && n < 12)
        begin
            @(posedge i_ref_clk);
            #1;
            n++;
        end
        wrdy <= 1'b0;
        chk("wake_len", 16'h8, 16'(n));
        chk("vector_wake", 16'h7, {6'h0, va});
        chk("hold_end", 16'h0, {15'h0, hold});
        ret_check();
    endtask : t_sleep

    // Main sequence
    initial
    begin
        repeat (12) @(posedge i_ref_clk);
        i_reset_n <= 1'b1;
        #1;
        chk("gie_rst", 16'h0, {15'h0, gie});
        chk("sp_rst", 16'h0, {8'h0, sp});
        @(posedge i_ref_clk);
        spld <= 1'b1;
        @(posedge i_ref_clk);
        spld <= 1'b0;
        t_flags();
        t_ops();
        t_level();
        t_sleep();
        report_and_stop();
    end
endmodule : cis_sequencer_tb
